/* rsq_readout.sv */
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ns
module rsq_readout (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [rsq_pkg::ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic READ_CLK,
  input wire logic TOKEN_IN_N,
  output logic TOKEN_OUT_N,
  input wire logic DIG_CLEAR,
  input wire logic PEAK_RESET,
  input wire logic [rsq_pkg::NUM_CH-1:0] CH_TRIG,
  input wire logic TRIG_PAIR_I,
  output logic TRIG_PAIR_O,
  output logic TRIG_PAIR_OE,
  input wire logic HOLD_N_I,
  output logic HOLD_N_O,
  output logic HOLD_N_OE,
  output logic HOLD_ACTIVE,
  output logic PEAK_START,
  output logic [rsq_pkg::NUM_CH-1:0] ENERGY_SEL,
  output logic [rsq_pkg::NUM_CH-1:0] TIME_SEL,
  output logic ENERGY_BUF_OE,
  output logic TIME_BUF_OE,
  output logic [rsq_pkg::NUM_CH-1:0] CAL_SEL
);
  import rsq_pkg::*;

  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] cfg_r;
  logic [63:0] test_r;
  logic [HDLY_W-1:0] hdly_r;
  logic cmd_clear_r;
  logic cmd_peak_r;
  logic req;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] rd_data;
  logic [31:0] status;
  logic [CH_IDX_W-1:0] ch_idx;
  logic clr_any;
  logic peak_rst_any;
  logic [NUM_CH-1:0] sel;
  logic buf_oe;
  logic int_hold;
  logic int_en;
  logic ext_en;
  logic cal_en;

  // ****************
  // Wishbone slave
  // ****************
  assign req = WB_CYC_I & WB_STB_I;
  // Writes land on the edge where the master sees ack
  assign wr = req & WB_WE_I & ack_r;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{WB_SEL_I[b]}};
    end
  endgenerate

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) ack_r <= 1'b0;
    else ack_r <= req & ~ack_r;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) dat_r <= 32'h0;
    else if (req & ~ack_r & ~WB_WE_I) dat_r <= rd_data;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) cfg_r <= CFG_RST;
    else if (wr && WB_ADR_I == ADDR_CONFIG)
      cfg_r <= ((cfg_r & ~wmask) | (WB_DAT_I & wmask)) & CFG_MASK;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) test_r <= TEST_RST;
    else if (wr && WB_ADR_I == ADDR_TEST_LO)
      test_r[31:0] <= (test_r[31:0] & ~wmask) | (WB_DAT_I & wmask);
    else if (wr && WB_ADR_I == ADDR_TEST_HI)
      test_r[63:32] <= (test_r[63:32] & ~wmask) | (WB_DAT_I & wmask);
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) hdly_r <= HDLY_RST;
    else if (wr && WB_ADR_I == ADDR_HDLY && WB_SEL_I[0]) hdly_r <= WB_DAT_I[HDLY_W-1:0];
  end

  // Command bits are one-cycle strobes, never stored
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cmd_clear_r <= 1'b0;
      cmd_peak_r <= 1'b0;
    end else begin
      cmd_clear_r <= wr && WB_ADR_I == ADDR_CMD && WB_SEL_I[0] && WB_DAT_I[CMD_CLEAR_BIT];
      cmd_peak_r <= wr && WB_ADR_I == ADDR_CMD && WB_SEL_I[0] && WB_DAT_I[CMD_PEAK_RST_BIT];
    end
  end

  always_comb begin
    ch_idx = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (sel[i]) ch_idx = CH_IDX_W'(i);
    end
  end

  always_comb begin
    status = 32'h0;
    status[ST_SEL_BIT] = |sel;
    status[ST_OE_BIT] = buf_oe;
    status[ST_HOLD_BIT] = HOLD_ACTIVE;
    status[ST_INT_HOLD_BIT] = int_hold;
    status[ST_TOKOUT_BIT] = ~TOKEN_OUT_N;
    status[ST_PEAK_BIT] = PEAK_START;
    status[ST_CH_LSB +: CH_IDX_W] = ch_idx;
  end

  // Unmapped and write-only addresses read as zero
  always_comb begin
    if (WB_ADR_I == ADDR_CONFIG) rd_data = cfg_r;
    else if (WB_ADR_I == ADDR_TEST_LO) rd_data = test_r[31:0];
    else if (WB_ADR_I == ADDR_TEST_HI) rd_data = test_r[63:32];
    else if (WB_ADR_I == ADDR_HDLY) rd_data = {{(32-HDLY_W){1'b0}}, hdly_r};
    else if (WB_ADR_I == ADDR_STATUS) rd_data = status;
    else rd_data = 32'h0;
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;

  // ****************
  // Readout chain and hold logic
  // ****************
  assign clr_any = DIG_CLEAR | cmd_clear_r;
  assign peak_rst_any = PEAK_RESET | cmd_peak_r;
  assign int_en = cfg_r[CFG_INT_HOLD_BIT];
  assign ext_en = cfg_r[CFG_EXT_HOLD_BIT];
  assign cal_en = cfg_r[CFG_CAL_BIT];

  rsq_token_chain u_chain (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .read_clk(READ_CLK),
    .token_in_n(TOKEN_IN_N),
    .clear(clr_any),
    .sel(sel),
    .buf_oe(buf_oe),
    .token_out_n(TOKEN_OUT_N)
  );

  rsq_hold_gen u_hold (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .ch_trig(CH_TRIG),
    .trig_pair_i(TRIG_PAIR_I),
    .int_en(int_en),
    .ext_en(ext_en),
    .delay_code(hdly_r),
    .ext_hold_n(HOLD_N_I),
    .clear(clr_any),
    .peak_reset(peak_rst_any),
    .trig_oe(TRIG_PAIR_OE),
    .peak_start(PEAK_START),
    .int_hold(int_hold),
    .hold_active(HOLD_ACTIVE)
  );

  // Both multiplexers share one select so they cannot drift apart
  assign ENERGY_SEL = sel;
  assign TIME_SEL = sel;
  assign ENERGY_BUF_OE = buf_oe;
  assign TIME_BUF_OE = buf_oe;
  // Open-drain style pads only ever pull low
  assign TRIG_PAIR_O = 1'b0;
  assign HOLD_N_O = 1'b0;
  assign HOLD_N_OE = int_hold;
  // Gated by the token select, so at most one channel sees calibration
  assign CAL_SEL = sel & test_r & {NUM_CH{cal_en}};

  // ****************
  // Checks
  // ****************
  logic ah_rclk_d_r;
  logic ah_fall;
  logic ah_rise;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) ah_rclk_d_r <= 1'b0;
    else ah_rclk_d_r <= READ_CLK;
  end

  assign ah_fall = ~READ_CLK & ah_rclk_d_r;
  assign ah_rise = READ_CLK & ~ah_rclk_d_r;

  a_one_channel: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N) $onehot0(ENERGY_SEL))
    else $error("more than one channel selected");

  a_mux_lockstep: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (ENERGY_SEL == TIME_SEL) && (ENERGY_BUF_OE == TIME_BUF_OE))
    else $error("multiplexers out of step");

  a_stopped_clock: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (!ah_fall && !clr_any) |=> $stable(ENERGY_SEL))
    else $error("select moved without a falling readout edge");

  a_token_steps: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (ah_fall && !clr_any && (ENERGY_SEL != 64'h0) && !ENERGY_SEL[63])
    |=> (ENERGY_SEL == ($past(ENERGY_SEL) << 1)))
    else $error("token did not step one channel");

  a_first_channel: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    $rose(ENERGY_BUF_OE) |-> (ENERGY_SEL == 64'h1) && $past(ah_fall))
    else $error("buffer enabled without channel 0 on a falling edge");

  a_buffer_gate: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    ENERGY_BUF_OE == (ENERGY_SEL != 64'h0))
    else $error("buffer enable disagrees with select");

  a_token_out: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    $fell(TOKEN_OUT_N) |-> ENERGY_SEL[63] && $past(ah_rise))
    else $error("token out without last channel");

  a_past_last: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (ENERGY_SEL[63] && !TOKEN_OUT_N && ah_fall && !clr_any)
    |=> (ENERGY_SEL == 64'h0) && !ENERGY_BUF_OE)
    else $error("select not emptied after last channel");

  a_clear_empties: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    clr_any |=> (ENERGY_SEL == 64'h0) && !ENERGY_BUF_OE && TOKEN_OUT_N)
    else $error("clear left the chain busy");

  a_trigger_drive: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (|CH_TRIG) |=> TRIG_PAIR_OE && PEAK_START)
    else $error("trigger did not drive pair or peak hold");

  a_int_hold_delay: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N || clr_any)
    (int_en && (|CH_TRIG) && !int_hold) |-> ##[1:20] int_hold)
    else $error("internal hold not generated in time");

  a_ext_hold_delay: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N || clr_any)
    (ext_en && !TRIG_PAIR_I && !int_hold) |-> ##[1:20] HOLD_N_OE)
    else $error("sensed trigger did not produce hold");

  a_hold_sources: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (!HOLD_N_I || (int_hold && !clr_any)) |=> HOLD_ACTIVE)
    else $error("a hold source was ignored");

  a_cal_gate: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (CAL_SEL != 64'h0) |-> cal_en && ((CAL_SEL & ~test_r) == 64'h0))
    else $error("calibration without both enables");

  a_cal_follows: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    $onehot0(CAL_SEL) && ((CAL_SEL & ~ENERGY_SEL) == 64'h0))
    else $error("calibration on an unselected channel");

  a_buffer_idle: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (!ENERGY_BUF_OE && !ah_fall) |=> !ENERGY_BUF_OE)
    else $error("buffer enabled without a falling readout edge");

  a_daisy_hold: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (!TOKEN_OUT_N && ah_fall && !clr_any) |=> !TOKEN_OUT_N)
    else $error("token out dropped before the next chip took over");

  a_chain_idle: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (!TOKEN_OUT_N && ah_rise && (ENERGY_SEL == 64'h0) && !clr_any) |=> TOKEN_OUT_N)
    else $error("token out stuck after a complete readout");

  a_clear_hold: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (clr_any && int_hold) |=> !HOLD_N_OE)
    else $error("clear did not release internal hold");

  a_peak_clear: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (peak_rst_any && !(|CH_TRIG)) |=> !PEAK_START)
    else $error("peak reset ignored");
endmodule

/* rsq_pkg.sv */
package rsq_pkg;
  // ****************
  // Geometry and timing
  // ****************
  localparam int NUM_CH = 64;
  localparam int CH_IDX_W = 6;
  localparam int CLK_PERIOD_NS = 50;
  localparam int HDLY_W = 4;
  localparam int DLY_CNT_W = 5;
  localparam int HOLD_DELAY_NS [16] = '{250, 125, 83, 63, 50, 38, 36, 31,
                                        250, 278, 313, 357, 375, 500, 625, 830};
  // ****************
  // Register map
  // ****************
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_TEST_LO = 8'h04;
  localparam logic [7:0] ADDR_TEST_HI = 8'h08;
  localparam logic [7:0] ADDR_HDLY = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CMD = 8'h14;
  localparam int CFG_EXT_HOLD_BIT = 16;
  localparam int CFG_INT_HOLD_BIT = 17;
  localparam int CFG_CAL_BIT = 19;
  localparam logic [31:0] CFG_MASK = 32'h000b_0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [63:0] TEST_RST = 64'h0;
  localparam logic [HDLY_W-1:0] HDLY_RST = 4'h0;
  localparam int ST_SEL_BIT = 0;
  localparam int ST_OE_BIT = 1;
  localparam int ST_HOLD_BIT = 2;
  localparam int ST_INT_HOLD_BIT = 3;
  localparam int ST_TOKOUT_BIT = 4;
  localparam int ST_PEAK_BIT = 5;
  localparam int ST_CH_LSB = 8;
  localparam int CMD_CLEAR_BIT = 0;
  localparam int CMD_PEAK_RST_BIT = 1;

  typedef enum logic [1:0] {
    HOLD_IDLE = 2'b00,
    HOLD_DELAY = 2'b01,
    HOLD_HELD = 2'b10
  } rsq_hold_state_type;

  function automatic logic [DLY_CNT_W-1:0] hold_cycles(input logic [HDLY_W-1:0] code);
    int c;
    c = (HOLD_DELAY_NS[code] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) c = 1;
    return DLY_CNT_W'(c);
  endfunction
endpackage

/* rsq_token_chain.sv */
`timescale 1ns/1ns
module rsq_token_chain (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic read_clk,
  input wire logic token_in_n,
  input wire logic clear,
  output logic [rsq_pkg::NUM_CH-1:0] sel,
  output logic buf_oe,
  output logic token_out_n
);
  import rsq_pkg::*;

  logic rclk_d_r;
  logic rise;
  logic fall;
  logic load;
  logic [NUM_CH-1:0] token_r;
  logic [NUM_CH-1:0] sel_r;
  logic oe_r;
  logic tout_r;

  // ****************
  // Readout clock edges
  // ****************
  assign rise = read_clk & ~rclk_d_r;
  assign fall = ~read_clk & rclk_d_r;
  // A second token is refused while one is in any of the first 63 stages; it is accepted once the first reaches the last stage
  assign load = ~token_in_n & (token_r[NUM_CH-2:0] == '0);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rclk_d_r <= 1'b0;
    else rclk_d_r <= read_clk;
  end

  // ****************
  // Token shift, output select, token out
  // ****************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) token_r <= '0;
    else if (clear) token_r <= '0;
    else if (rise) token_r <= {token_r[NUM_CH-2:0], load};
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_r <= '0;
      oe_r <= 1'b0;
    end else if (clear) begin
      sel_r <= '0;
      oe_r <= 1'b0;
    end else if (fall) begin
      sel_r <= token_r;
      oe_r <= |token_r;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) tout_r <= 1'b0;
    else if (clear) tout_r <= 1'b0;
    else if (rise) tout_r <= token_r[NUM_CH-1];
  end

  assign sel = sel_r;
  assign buf_oe = oe_r;
  assign token_out_n = ~tout_r;
endmodule

/* rsq_hold_gen.sv */
`timescale 1ns/1ns
module rsq_hold_gen (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [rsq_pkg::NUM_CH-1:0] ch_trig,
  input wire logic trig_pair_i,
  input wire logic int_en,
  input wire logic ext_en,
  input wire logic [rsq_pkg::HDLY_W-1:0] delay_code,
  input wire logic ext_hold_n,
  input wire logic clear,
  input wire logic peak_reset,
  output logic trig_oe,
  output logic peak_start,
  output logic int_hold,
  output logic hold_active
);
  import rsq_pkg::*;

  rsq_hold_state_type state_r;
  rsq_hold_state_type state_nxt;
  logic [DLY_CNT_W-1:0] cnt_r;
  logic any_trig;
  logic start;
  logic trig_oe_r;
  logic peak_r;
  logic hold_r;

  assign any_trig = |ch_trig;
  assign start = (int_en & any_trig) | (ext_en & ~trig_pair_i);

  // ****************
  // Internal hold sequencer
  // ****************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HOLD_IDLE: if (start) state_nxt = HOLD_DELAY;
      HOLD_DELAY: if (cnt_r == '0) state_nxt = HOLD_HELD;
      HOLD_HELD: state_nxt = HOLD_HELD;
      default: state_nxt = HOLD_IDLE;
    endcase
    // Clear loses only to a hold that expires in the same cycle
    if (clear && !(state_r == HOLD_DELAY && cnt_r == '0)) state_nxt = HOLD_IDLE;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) state_r <= HOLD_IDLE;
    else state_r <= state_nxt;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt_r <= '0;
    else if (state_r == HOLD_IDLE && start) cnt_r <= hold_cycles(delay_code) - 1'b1;
    else if (state_r == HOLD_DELAY && cnt_r != '0) cnt_r <= cnt_r - 1'b1;
  end

  // ****************
  // Trigger drive, peak hold, sampled hold
  // ****************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_oe_r <= 1'b0;
      peak_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      trig_oe_r <= any_trig;
      if (any_trig) peak_r <= 1'b1;
      else if (peak_reset) peak_r <= 1'b0;
      hold_r <= (state_nxt == HOLD_HELD) | ~ext_hold_n;
    end
  end

  assign trig_oe = trig_oe_r;
  assign peak_start = peak_r;
  assign int_hold = (state_r == HOLD_HELD);
  assign hold_active = hold_r;
endmodule

/* rsq_ctrl_model.sv */
`timescale 1ns/1ns
// ****************
// Readout controller model
// ****************
module rsq_ctrl_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n_clk,
  input wire logic [3:0] half,
  output logic read_clk,
  output logic token_in_n,
  output logic hold_drv,
  output logic busy
);
  // Clock stands low outside a frame; half must be at least 1
  initial begin
    read_clk = 1'b0;
    token_in_n = 1'b1;
    hold_drv = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go && !busy) begin
        busy <= 1'b1;
        hold_drv <= 1'b1;
        repeat (4) @(posedge clk);
        token_in_n <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < n_clk; i++) begin
          read_clk <= 1'b1;
          // First pulse stretched to 100 ns when half is 1; the token is released as it falls
          repeat ((i == 0 && half < 2) ? 2 : half) @(posedge clk);
          read_clk <= 1'b0;
          token_in_n <= 1'b1;
          repeat (half) @(posedge clk);
        end
        repeat (2) @(posedge clk);
        hold_drv <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import rsq_pkg::*;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [31:0] e;
  } rsq_row_type;
  localparam rsq_row_type ROWS [13] = '{
    '{1'b0, ADDR_CONFIG, 32'h0, 4'h0, CFG_RST},
    '{1'b0, ADDR_TEST_LO, 32'h0, 4'h0, TEST_RST[31:0]},
    '{1'b0, ADDR_TEST_HI, 32'h0, 4'h0, TEST_RST[63:32]},
    '{1'b0, ADDR_HDLY, 32'h0, 4'h0, 32'(HDLY_RST)},
    '{1'b1, ADDR_CONFIG, 32'hffff_ffff, 4'hf, CFG_MASK},
    '{1'b1, ADDR_CONFIG, 32'h0, 4'hb, CFG_MASK},
    '{1'b1, ADDR_CONFIG, 32'h0, 4'hf, 32'h0},
    '{1'b1, ADDR_TEST_LO, 32'h89ab_cdef, 4'hf, 32'h89ab_cdef},
    '{1'b1, ADDR_TEST_LO, 32'h0, 4'h1, 32'h89ab_cd00},
    '{1'b1, ADDR_TEST_HI, 32'h1234_5678, 4'hc, 32'h1234_0000},
    '{1'b1, ADDR_HDLY, 32'hff, 4'h1, 32'hf},
    '{1'b1, ADDR_HDLY, 32'h3, 4'he, 32'hf},
    '{1'b1, 8'h20, 32'hffff_ffff, 4'hf, 32'h0}};
  logic ref_clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, rclk, tok_in, tok_out, dig_clr = 1'b0, pk_rst = 1'b0, tb_trig = 1'b0;
  logic [63:0] ch_trig = 64'h0, e_sel, t_sel, cal_sel, prev_sel = 64'h0, test_bits = 64'h0;
  logic tp_o, tp_oe, hold_o, hold_oe, hold_act, pk_start, e_oe, t_oe, m_hold, m_busy;
  logic m_go = 1'b0, cal_en = 1'b0, prev_rclk = 1'b0, prev_tok = 1'b1;
  logic [7:0] m_n = 8'h0;
  logic [3:0] m_half = 4'h1;
  logic trig_line, hold_line;
  int miscompares = 0, total_checks = 0, exp_ch = 0, steps = 0, since_fall = 0;
  int tok_lows = 0, cal_hits = 0;
  // Open-drain wires: low while any party pulls
  assign trig_line = !((tp_oe && !tp_o) || tb_trig);
  assign hold_line = !((hold_oe && !hold_o) || m_hold);
  initial forever #25 ref_clk = ~ref_clk;

  rsq_readout dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .READ_CLK(rclk), .TOKEN_IN_N(tok_in), .TOKEN_OUT_N(tok_out),
    .DIG_CLEAR(dig_clr), .PEAK_RESET(pk_rst), .CH_TRIG(ch_trig), .TRIG_PAIR_I(trig_line),
    .TRIG_PAIR_O(tp_o), .TRIG_PAIR_OE(tp_oe), .HOLD_N_I(hold_line), .HOLD_N_O(hold_o),
    .HOLD_N_OE(hold_oe), .HOLD_ACTIVE(hold_act), .PEAK_START(pk_start),
    .ENERGY_SEL(e_sel), .TIME_SEL(t_sel), .ENERGY_BUF_OE(e_oe), .TIME_BUF_OE(t_oe),
    .CAL_SEL(cal_sel));
  rsq_ctrl_model ctrl (.clk(ref_clk), .go(m_go), .n_clk(m_n), .half(m_half),
    .read_clk(rclk), .token_in_n(tok_in), .hold_drv(m_hold), .busy(m_busy));

  // ****************
  // Shared tasks
  // ****************
  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge ref_clk);
    if (n >= 20) begin
      miscompares++;
      $display("Error at %0t: bus timeout", $time);
      results();
    end
  endtask
  task automatic run_ro(input int n, input int h);
    int t;
    m_n <= 8'(n);
    m_half <= 4'(h);
    m_go <= 1'b1;
    @(posedge ref_clk);
    m_go <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(hold_act, 1, "pad hold");
    t = 0;
    while (m_busy !== 1'b0 && t < 3000) begin
      @(posedge ref_clk);
      t++;
    end
    if (t >= 3000) begin
      miscompares++;
      $display("Error at %0t: readout timeout", $time);
      results();
    end
  endtask

  // Output watcher; a step must follow a clock fall closely
  always @(negedge ref_clk) begin
    if (arst_n) begin
      since_fall = (prev_rclk && !rclk) ? 0 : since_fall + 1;
      if (e_sel !== prev_sel && e_sel !== 64'h0) begin
        total_checks++;
        if (e_sel !== (64'h1 << exp_ch) || since_fall > 3) begin
          miscompares++;
          $display("Error at %0t: step to %h", $time, e_sel);
        end
        exp_ch++;
        if (cal_sel !== 64'h0) cal_hits++;
      end
      if (e_sel === 64'h0 && prev_sel !== 64'h0) steps = exp_ch;
      if (e_sel === 64'h0) exp_ch = 0;
      total_checks++;
      if (!$onehot0(e_sel) || t_sel !== e_sel || e_oe !== (|e_sel) || t_oe !== e_oe
          || cal_sel !== (e_sel & test_bits & {64{cal_en}})) begin
        miscompares++;
        $display("Error at %0t: mux state %h", $time, e_sel);
      end
      if (prev_tok === 1'b1 && tok_out === 1'b0) begin
        tok_lows++;
        total_checks++;
        if (e_sel[63] !== 1'b1) begin
          miscompares++;
          $display("Error at %0t: early token out", $time);
        end
      end
      prev_sel = e_sel;
      prev_rclk = rclk;
      prev_tok = tok_out;
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [31:0] q;
    int n;
    int k;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 13; i++) begin
      if (ROWS[i].w) wb(1'b1, ROWS[i].a, ROWS[i].d, ROWS[i].s, q);
      wb(1'b0, ROWS[i].a, 32'h0, 4'hf, q);
      chk(q, ROWS[i].e, "register");
    end
    test_bits = {32'h1234_0000, 32'h89ab_cd00};
    run_ro(66, 1);
    chk(steps, 64, "steps");
    chk(tok_lows, 1, "token out");
    chk({e_oe, tok_out}, 2'b01, "after last");
    run_ro(5, 8);
    repeat (10) @(posedge ref_clk);
    chk(e_sel, 64'h10, "stopped clock");
    wb(1'b0, ADDR_STATUS, 32'h0, 4'hf, q);
    chk(q, (32'h1 << ST_SEL_BIT) | (32'h1 << ST_OE_BIT) | (32'h4 << ST_CH_LSB), "status");
    dig_clr <= 1'b1;
    @(posedge ref_clk);
    dig_clr <= 1'b0;
    @(posedge ref_clk);
    chk(e_sel, 64'h0, "clear");
    chk(e_oe, 0, "clear buffer");
    chk(steps, 5, "partial steps");
    run_ro(3, 1);
    arst_n <= 1'b0;
    @(posedge ref_clk);
    chk(e_sel, 64'h0, "mid reset");
    chk(tok_out, 1, "mid reset token");
    arst_n <= 1'b1;
    @(posedge ref_clk);
    // Reset empties the test bits, so they are loaded again
    wb(1'b0, ADDR_TEST_LO, 32'h0, 4'hf, q);
    chk(q, TEST_RST[31:0], "test bits after reset");
    wb(1'b1, ADDR_TEST_LO, test_bits[31:0], 4'hf, q);
    wb(1'b1, ADDR_TEST_HI, test_bits[63:32], 4'hf, q);
    wb(1'b1, ADDR_CONFIG, 32'h1 << CFG_CAL_BIT, 4'hf, q);
    cal_en = 1'b1;
    cal_hits = 0;
    run_ro(66, 1);
    chk(cal_hits, $countones(test_bits), "cal hits");
    wb(1'b1, ADDR_CONFIG, 32'h1 << CFG_INT_HOLD_BIT, 4'hf, q);
    cal_en = 1'b0;
    for (int c = 0; c < 16; c++) begin
      n = (HOLD_DELAY_NS[c] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      wb(1'b1, ADDR_HDLY, 32'(c), 4'h1, q);
      ch_trig <= 64'h1 << (4 * c);
      @(posedge ref_clk);
      ch_trig <= 64'h0;
      #1;
      chk({pk_start, tp_oe}, 2'b11, "trigger");
      k = 0;
      while (hold_oe !== 1'b1 && k < 40) begin
        @(posedge ref_clk);
        #1;
        k++;
      end
      chk(k, n, "hold delay");
      chk(hold_act, 1, "hold active");
      @(posedge ref_clk);
      wb(1'b1, ADDR_CMD, 32'h1 << CMD_CLEAR_BIT, 4'h1, q);
      pk_rst <= 1'b1;
      @(posedge ref_clk);
      pk_rst <= 1'b0;
      #1;
      chk({hold_oe, pk_start}, 2'b00, "clear hold");
      @(posedge ref_clk);
    end
    // Pair trigger ignored while only the own-trigger mode is on
    tb_trig <= 1'b1;
    @(posedge ref_clk);
    tb_trig <= 1'b0;
    repeat (25) @(posedge ref_clk);
    chk(hold_oe, 0, "no pair hold");
    wb(1'b1, ADDR_CONFIG, 32'h1 << CFG_EXT_HOLD_BIT, 4'hf, q);
    tb_trig <= 1'b1;
    @(posedge ref_clk);
    tb_trig <= 1'b0;
    k = 0;
    while (hold_oe !== 1'b1 && k < 40) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk(k, (HOLD_DELAY_NS[15] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS, "pair hold");
    results();
  end
endmodule
